// ===== rtl/clk_switch_ctrl.sv
// Purpose: Request, readback and switch handshake for the system clock source.
// Assumes: Fuses are stable levels; oscillator ready lines come from other clocks.
// Notes:   Request and current reset defaults follow the fuses, captured at each reset cycle.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns

// Overview of operation
// - Source code 7 ext, 6 HF, 5 LF, 4 secondary
// - Requested source resets to reset-source fuse
// - Reserved source write discards whole write
// - Permit fuse low makes request read-only
// - Divider resets 0010 for HF, else 0000
// - Divider code is power of two, 0-9
// - Current register shows source and divider
// - Current equals request after reset
// - Hold set suspends switch, raises interrupt
// - Hold clear at ready performs switch
// - Control bit 6 selects secondary power
// - Done flag set when current equals request
// - New-ready flag only during ready switch
// - Oscillator ready flags in status bits 7-2
// - PLL usable flag in status bit 0
// - Current power-on value is running selection
// - Completion updates current, sets done, clears ready
// - Sleep before changeover start cancels the switch
// - Ready sets new-ready and interrupt together
module clk_switch_ctrl
  import clk_switch_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  input  wire logic [2:0] reset_source_fuse_i,
  input  wire logic       switch_permit_fuse_i,
  input  wire logic       sleep_i,
  input  wire logic [6:0] osc_ready_i,
  input  wire logic       pll_locked_i,
  output logic            switch_interrupt_flag_o,
  output logic            secondary_osc_power_o,
  output logic [6:0]      mux_select_o,
  output logic            mux_gate_o
);
  // osc_ready_i: [6] ext, [5] HF, [4] MF, [3] LF, [2] secondary, [1] fast RC, [0] PLL input.
  logic [6:0] ready_meta_reg;
  logic [6:0] ready_sync_reg;
  logic       pll_meta_reg;
  logic       pll_sync_reg;

  logic [2:0] requested_source_reg;
  logic [2:0] requested_source_next;
  logic [3:0] requested_divider_reg;
  logic [3:0] requested_divider_next;
  logic [2:0] current_source_reg;
  logic [2:0] current_source_next;
  logic [3:0] current_divider_reg;
  logic [3:0] current_divider_next;
  logic       switch_hold_reg;
  logic       switch_hold_next;
  logic       secondary_osc_power_reg;
  logic       secondary_osc_power_next;
  logic       new_source_ready_reg;
  logic       new_source_ready_next;
  logic       irq_reg;
  logic       irq_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  switch_state_type state_reg;
  switch_state_type state_next;

  logic       switch_pending;
  logic       target_ready;
  logic       change_start;
  logic       change_done;
  logic       request_write;
  logic       source_reserved;
  logic       divider_reserved;
  logic [3:0] fuse_divider;
  logic       pll_usable;
  logic [7:0] status_word;

  // Ready lines come from other oscillators, so each passes two flops.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ready_meta_reg <= 7'h00;
      ready_sync_reg <= 7'h00;
      pll_meta_reg   <= 1'b0;
      pll_sync_reg   <= 1'b0;
    end else begin
      ready_meta_reg <= osc_ready_i;
      ready_sync_reg <= ready_meta_reg;
      pll_meta_reg   <= pll_locked_i;
      pll_sync_reg   <= pll_meta_reg;
    end
  end

  // The PLL only counts as usable when both its lock and its input are good.
  always_comb begin
    pll_usable = 1'b0;
    case (requested_source_reg)
      SRC_EXT_PLL4: pll_usable = pll_sync_reg & ready_sync_reg[6];
      SRC_HF_PLL2:  pll_usable = pll_sync_reg & ready_sync_reg[5];
      default:      pll_usable = pll_sync_reg & ready_sync_reg[0];
    endcase
  end

  always_comb begin
    target_ready = 1'b0;
    case (requested_source_reg)
      SRC_EXTERNAL:    target_ready = ready_sync_reg[6];
      SRC_HF_1MHZ:     target_ready = ready_sync_reg[5];
      SRC_LF_INTERNAL: target_ready = ready_sync_reg[3];
      SRC_SECONDARY:   target_ready = ready_sync_reg[2];
      SRC_EXT_PLL4:    target_ready = pll_usable;
      SRC_HF_PLL2:     target_ready = pll_usable;
      default:         target_ready = 1'b0;
    endcase
  end

  assign fuse_divider = (reset_source_fuse_i == SRC_HF_1MHZ) ? DIV_HF_RESET : DIV_OTHER_RESET;
  assign switch_pending = (requested_source_reg != current_source_reg) ||
                          (requested_divider_reg != current_divider_reg);
  assign request_write = wr_i && (addr_i == ADDR_REQUEST) && switch_permit_fuse_i;
  assign source_reserved = (wdata_i[SRC_MSB:SRC_LSB] == SRC_RESERVED_HI) ||
                           (wdata_i[SRC_MSB:SRC_LSB] == SRC_RESERVED_LO);
  // Reserved divider codes are refused as well so the readback never shows them.
  assign divider_reserved = (wdata_i[DIV_MSB:DIV_LSB] > DIV_MAX_CODE);

  always_comb begin
    requested_source_next    = requested_source_reg;
    requested_divider_next   = requested_divider_reg;
    switch_hold_next         = switch_hold_reg;
    secondary_osc_power_next = secondary_osc_power_reg;
    if (request_write && !source_reserved && !divider_reserved) begin
      requested_source_next  = wdata_i[SRC_MSB:SRC_LSB];
      requested_divider_next = wdata_i[DIV_MSB:DIV_LSB];
    end
    if (wr_i && (addr_i == ADDR_CONTROL)) begin
      switch_hold_next         = wdata_i[HOLD_BIT];
      secondary_osc_power_next = wdata_i[SECONDARY_OSCILLATOR_PWR_BIT];
    end
  end

  always_comb begin
    state_next            = state_reg;
    current_source_next   = current_source_reg;
    current_divider_next  = current_divider_reg;
    new_source_ready_next = new_source_ready_reg;
    irq_next              = 1'b0;
    change_start          = 1'b0;
    case (state_reg)
      SW_IDLE: begin
        new_source_ready_next = 1'b0;
        if (switch_pending && !sleep_i) begin
          state_next = SW_WAIT;
        end
      end
      SW_WAIT: begin
        if (sleep_i || !switch_pending) begin
          state_next = SW_IDLE;
        end else if (target_ready) begin
          new_source_ready_next = 1'b1;
          irq_next              = 1'b1;
          state_next            = switch_hold_reg ? SW_HELD : SW_CHANGE;
          change_start          = !switch_hold_reg;
        end
      end
      SW_HELD: begin
        // Old clock keeps running until software releases, or sleep, a request rewritten to match current or lost ready abandons.
        if (sleep_i || !switch_pending || !target_ready) begin
          new_source_ready_next = 1'b0;
          state_next            = SW_IDLE;
        end else if (!switch_hold_reg) begin
          change_start = 1'b1;
          state_next   = SW_CHANGE;
        end
      end
      SW_CHANGE: begin
        if (change_done) begin
          current_source_next   = requested_source_reg;
          current_divider_next  = requested_divider_reg;
          new_source_ready_next = 1'b0;
          state_next            = SW_IDLE;
        end
      end
      default: state_next = SW_IDLE;
    endcase
  end

  clk_changeover u_changeover (
    .sys_clk_i    (sys_clk_i),
    .rst_i        (rst_i),
    .start_i      (change_start),
    .target_i     ({requested_source_reg, requested_divider_reg}),
    .done_o       (change_done),
    .mux_select_o (mux_select_o),
    .mux_gate_o   (mux_gate_o)
  );

  assign status_word = {ready_sync_reg[6], ready_sync_reg[5], ready_sync_reg[4], ready_sync_reg[3],
                        ready_sync_reg[2], ready_sync_reg[1], 1'b0, pll_usable};

  always_comb begin
    rdata_next = READ_ZERO;
    if (rd_i) begin
      case (addr_i)
        ADDR_REQUEST: rdata_next = {1'b0, requested_source_reg, requested_divider_reg};
        ADDR_CURRENT: rdata_next = {1'b0, current_source_reg, current_divider_reg};
        ADDR_CONTROL: rdata_next = {switch_hold_reg, secondary_osc_power_reg, 1'b0,
                                    !switch_pending, new_source_ready_reg && switch_pending,
                                    3'h0};
        ADDR_STATUS:  rdata_next = status_word;
        default:      rdata_next = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      requested_source_reg    <= reset_source_fuse_i;
      requested_divider_reg   <= fuse_divider;
      current_source_reg      <= reset_source_fuse_i;
      current_divider_reg     <= fuse_divider;
      switch_hold_reg         <= CONTROL_RESET[HOLD_BIT];
      secondary_osc_power_reg <= CONTROL_RESET[SECONDARY_OSCILLATOR_PWR_BIT];
      new_source_ready_reg    <= 1'b0;
      irq_reg                 <= 1'b0;
      rdata_reg               <= READ_ZERO;
      state_reg               <= SW_IDLE;
    end else begin
      requested_source_reg    <= requested_source_next;
      requested_divider_reg   <= requested_divider_next;
      current_source_reg      <= current_source_next;
      current_divider_reg     <= current_divider_next;
      switch_hold_reg         <= switch_hold_next;
      secondary_osc_power_reg <= secondary_osc_power_next;
      new_source_ready_reg    <= new_source_ready_next;
      irq_reg                 <= irq_next;
      rdata_reg               <= rdata_next;
      state_reg               <= state_next;
    end
  end

  // The interrupt flag is a one-cycle request; the interrupt controller keeps it sticky.
  always_comb begin
    switch_interrupt_flag_o = irq_reg;
  end

  assign rdata_o               = rdata_reg;
  assign secondary_osc_power_o = secondary_osc_power_reg;
endmodule

// ===== rtl/clk_switch_pkg.sv
// Purpose: Shared constants for the system clock switch control block.
// Assumes: 8-bit registers reached over a plain strobe port.
// Notes:   Register offsets are word indexes on the plain port.
package clk_switch_pkg;
  localparam logic [1:0] ADDR_REQUEST = 2'h0;
  localparam logic [1:0] ADDR_CURRENT = 2'h1;
  localparam logic [1:0] ADDR_CONTROL = 2'h2;
  localparam logic [1:0] ADDR_STATUS  = 2'h3;

  localparam int SRC_MSB = 6;
  localparam int SRC_LSB = 4;
  localparam int DIV_MSB = 3;
  localparam int DIV_LSB = 0;
  localparam int HOLD_BIT = 7;
  localparam int SECONDARY_OSCILLATOR_PWR_BIT = 6;
  localparam int DONE_BIT = 4;
  localparam int NEW_READY_BIT = 3;
  localparam int PLL_READY_BIT = 0;

  localparam logic [2:0] SRC_EXTERNAL     = 3'h7;
  localparam logic [2:0] SRC_HF_1MHZ      = 3'h6;
  localparam logic [2:0] SRC_LF_INTERNAL  = 3'h5;
  localparam logic [2:0] SRC_SECONDARY    = 3'h4;
  localparam logic [2:0] SRC_RESERVED_HI  = 3'h3;
  localparam logic [2:0] SRC_EXT_PLL4     = 3'h2;
  localparam logic [2:0] SRC_HF_PLL2      = 3'h1;
  localparam logic [2:0] SRC_RESERVED_LO  = 3'h0;

  localparam logic [3:0] DIV_HF_RESET     = 4'h2;
  localparam logic [3:0] DIV_OTHER_RESET  = 4'h0;
  localparam logic [3:0] DIV_MAX_CODE     = 4'h9;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] READ_ZERO        = 8'h00;

  typedef enum logic [1:0] {
    SW_IDLE    = 2'b00,
    SW_WAIT    = 2'b01,
    SW_HELD    = 2'b10,
    SW_CHANGE  = 2'b11
  } switch_state_type;
endpackage

// ===== rtl/clk_changeover.sv
// Purpose: Glitch-free changeover handshake between old and new selection.
// Assumes: Clock gating happens in the analog mux driven by mux_select_o.
// Notes:   The old clock is gated off first, then the new one is enabled.
`timescale 1ns/1ns
module clk_changeover
  import clk_switch_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [6:0] target_i,
  output logic            done_o,
  output logic [6:0]      mux_select_o,
  output logic            mux_gate_o
);
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic [6:0] sel_reg;
  logic [6:0] sel_next;
  logic       gate_reg;
  logic       gate_next;

  // The gate stays low for two whole cycles, one each side of the mux select change,
  // so no shortened pulse can pass.
  always_comb begin
    phase_next = phase_reg;
    sel_next   = sel_reg;
    gate_next  = gate_reg;
    case (phase_reg)
      2'h0: begin
        if (start_i) begin
          gate_next  = 1'b0;
          phase_next = 2'h1;
        end
      end
      2'h1: begin
        sel_next   = target_i;
        phase_next = 2'h2;
      end
      2'h2: begin
        gate_next  = 1'b1;
        phase_next = 2'h0;
      end
      default: phase_next = 2'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    // Reset loads the fuse selection so the mux runs what the readback reports.
    if (rst_i) begin
      phase_reg <= 2'h0;
      sel_reg   <= target_i;
      gate_reg  <= 1'b1;
    end else begin
      phase_reg <= phase_next;
      sel_reg   <= sel_next;
      gate_reg  <= gate_next;
    end
  end

  assign done_o       = (phase_reg == 2'h2);
  assign mux_select_o = sel_reg;
  assign mux_gate_o   = gate_reg;
endmodule

// ===== tb/clk_switch_ctrl_assertions.sv
// Purpose: Port-level checks for the clock switch control block.
// Assumes: Fuses hold static levels whenever reset is low.
// Notes:   Bound to every instance of the control block.
`timescale 1ns/1ns
module clk_switch_ctrl_checker
  import clk_switch_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [2:0] reset_source_fuse_i,
  input wire logic       switch_permit_fuse_i,
  input wire logic       secondary_osc_power_o,
  input wire logic [6:0] mux_select_o,
  input wire logic       mux_gate_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_status_gap_zero: assert property ($past(rd_i) && $past(addr_i) == ADDR_STATUS |-> !rdata_o[1])
    else $error("status bit 1 read as one");
  a_control_gap_zero: assert property ($past(rd_i) && $past(addr_i) == ADDR_CONTROL |->
    !rdata_o[5] && rdata_o[2:0] == 3'h0) else $error("control unused bits read as one");
  a_select_top_zero: assert property ($past(rd_i) && !$past(addr_i[1]) |-> !rdata_o[7])
    else $error("selection bit 7 read as one");
  a_divider_in_range: assert property ($past(rd_i) && !$past(addr_i[1]) |->
    rdata_o[DIV_MSB:DIV_LSB] <= DIV_MAX_CODE) else $error("reserved divider code read back");
  a_current_not_reserved: assert property ($past(rd_i) && $past(addr_i) == ADDR_CURRENT |->
    rdata_o[6:4] != SRC_RESERVED_HI && rdata_o[6:4] != SRC_RESERVED_LO) else $error("reserved source in use");
  a_done_ready_apart: assert property ($past(rd_i) && $past(addr_i) == ADDR_CONTROL |->
    !(rdata_o[DONE_BIT] && rdata_o[NEW_READY_BIT])) else $error("done and new ready both set");
  a_power_follows: assert property (wr_i && addr_i == ADDR_CONTROL |=>
    secondary_osc_power_o == $past(wdata_i[SECONDARY_OSCILLATOR_PWR_BIT])) else $error("power select not taken");
  a_fuse_lock: assert property (!switch_permit_fuse_i && $past(rd_i) && $past(addr_i) == ADDR_REQUEST |->
    rdata_o[6:4] == reset_source_fuse_i) else $error("locked request changed");
  a_select_gated: assert property ($changed(mux_select_o) && !$past(rst_i) |-> !mux_gate_o)
    else $error("mux select moved while clock gate open");
  a_gate_returns: assert property ($fell(mux_gate_o) |-> ##[1:4] mux_gate_o)
    else $error("clock gate stayed closed");
endmodule

bind clk_switch_ctrl clk_switch_ctrl_checker chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .reset_source_fuse_i(reset_source_fuse_i), .switch_permit_fuse_i(switch_permit_fuse_i),
  .secondary_osc_power_o(secondary_osc_power_o), .mux_select_o(mux_select_o), .mux_gate_o(mux_gate_o));

// ===== tb/test_system_clock_switch_control.sv
// Purpose: Self-checking bench for the clock switch control block.
// Assumes: Ready lines settle within a few cycles of synchronisation.
// Notes:   Fixed waits cover the two-flop sync plus the changeover walk.
`timescale 1ns/1ns
module test_system_clock_switch_control;
  import clk_switch_pkg::*;
  logic       sys_clk_i, rst_i, wr_i, rd_i, sleep_i, pll_locked_i, switch_permit_fuse_i;
  logic       switch_interrupt_flag_o, secondary_osc_power_o, mux_gate_o, irq_seen;
  logic [1:0] addr_i;
  logic [2:0] reset_source_fuse_i;
  logic [6:0] osc_ready_i, mux_select_o;
  logic [7:0] wdata_i, rdata_o;
  int         num_errors, checked, cycles;

  clk_switch_ctrl uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .reset_source_fuse_i(reset_source_fuse_i),
    .switch_permit_fuse_i(switch_permit_fuse_i), .sleep_i(sleep_i), .osc_ready_i(osc_ready_i),
    .pll_locked_i(pll_locked_i), .switch_interrupt_flag_o(switch_interrupt_flag_o),
    .secondary_osc_power_o(secondary_osc_power_o), .mux_select_o(mux_select_o), .mux_gate_o(mux_gate_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (switch_interrupt_flag_o === 1'b1) irq_seen = 1'b1;
    if (cycles == 2000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is judged just past that edge.
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, e);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic t_defaults();
    rd(ADDR_REQUEST, 8'h62);
    rd(ADDR_CURRENT, 8'h62);
    rd(ADDR_CONTROL, 8'h10);
    check({mux_gate_o, mux_select_o}, 8'he2);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'ha8);
    $display("defaults and status done");
  endtask

  task automatic t_refused();
    wr(ADDR_REQUEST, 8'h35);
    wr(ADDR_REQUEST, 8'h0a);
    wr(ADDR_REQUEST, 8'h7a);
    wr(ADDR_CURRENT, 8'h11);
    rd(ADDR_REQUEST, 8'h62);
    rd(ADDR_CURRENT, 8'h62);
    $display("refused writes done");
  endtask

  task automatic t_switch();
    irq_seen = 1'b0;
    wr(ADDR_REQUEST, 8'h53);
    repeat (6) @(posedge sys_clk_i);
    rd(ADDR_CURRENT, 8'h62);
    rd(ADDR_CONTROL, 8'h00);
    check({7'h00, irq_seen}, 8'h00);
    osc_ready_i[3] <= 1'b1;
    repeat (12) @(posedge sys_clk_i);
    check({7'h00, irq_seen}, 8'h01);
    rd(ADDR_CURRENT, 8'h53);
    rd(ADDR_CONTROL, 8'h10);
    check({mux_gate_o, mux_select_o}, 8'hd3);
    $display("plain switch done");
  endtask

  task automatic t_hold();
    wr(ADDR_CONTROL, 8'hc0);
    irq_seen = 1'b0;
    wr(ADDR_REQUEST, 8'h40);
    repeat (12) @(posedge sys_clk_i);
    check({7'h00, secondary_osc_power_o}, 8'h01);
    rd(ADDR_CURRENT, 8'h53);
    rd(ADDR_CONTROL, 8'hc8);
    check({7'h00, irq_seen}, 8'h01);
    wr(ADDR_CONTROL, 8'h40);
    repeat (12) @(posedge sys_clk_i);
    rd(ADDR_CURRENT, 8'h40);
    rd(ADDR_CONTROL, 8'h50);
    check({mux_gate_o, mux_select_o}, 8'hc0);
    $display("held switch done");
  endtask

  task automatic t_sleep();
    sleep_i <= 1'b1;
    wr(ADDR_REQUEST, 8'h70);
    repeat (12) @(posedge sys_clk_i);
    rd(ADDR_CURRENT, 8'h40);
    wr(ADDR_REQUEST, 8'h40);
    sleep_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rd(ADDR_CONTROL, 8'h50);
    $display("sleep cancel done");
  endtask

  // The PLL source must wait for lock as well as for its input oscillator.
  task automatic t_pll();
    pll_locked_i <= 1'b0;
    wr(ADDR_REQUEST, 8'h20);
    repeat (6) @(posedge sys_clk_i);
    rd(ADDR_CURRENT, 8'h40);
    pll_locked_i <= 1'b1;
    repeat (12) @(posedge sys_clk_i);
    rd(ADDR_CURRENT, 8'h20);
    rd(ADDR_STATUS, 8'hb9);
    check({mux_gate_o, mux_select_o}, 8'ha0);
    $display("pll switch done");
  endtask

  task automatic t_locked();
    switch_permit_fuse_i <= 1'b0;
    reset_source_fuse_i  <= SRC_LF_INTERNAL;
    do_reset();
    wr(ADDR_REQUEST, 8'h62);
    rd(ADDR_REQUEST, 8'h50);
    rd(ADDR_CURRENT, 8'h50);
    $display("locked request done");
  endtask

  initial begin
    rst_i                = 1'b1;
    wr_i                 = 1'b0;
    rd_i                 = 1'b0;
    addr_i               = 2'h0;
    wdata_i              = 8'h00;
    sleep_i              = 1'b0;
    pll_locked_i         = 1'b0;
    switch_permit_fuse_i = 1'b1;
    reset_source_fuse_i  = SRC_HF_1MHZ;
    osc_ready_i          = 7'h55;
    irq_seen             = 1'b0;
    do_reset();
    t_defaults();
    t_refused();
    t_switch();
    t_hold();
    t_sleep();
    t_pll();
    t_locked();
    stop_test();
  end
endmodule
